// >>> core/udmaw_dev.sv
`timescale 1ns/10ps
module udmaw_dev #(
	parameter int DEPTH = udmaw_pkg::FIFO_DEPTH
) (
	input wire logic clock,
	input wire logic resetn,
	input wire udmaw_pkg::udmaw_hin_s host_in,
	output udmaw_pkg::udmaw_dout_s dev_out,
	input wire logic [2:0] mode,
	input wire logic burst_go,
	input wire logic burst_end,
	output logic rx_valid,
	input wire logic rx_ready,
	output logic [udmaw_pkg::DATA_W-1:0] rx_data,
	output logic busy,
	output logic done,
	output logic crc_err
);
	import udmaw_pkg::*;

	if (DEPTH < ROOM_MARGIN + 1)
	begin : g_depth_check
		$error("udmaw_dev: DEPTH too small for the pause margin");
	end

	// Pin synchroniser, three stages
	udmaw_hin_s sync1_r, sync2_r, sync3_r, filt_r, filt_nxt;
	logic strobe_edge, ack_on, stop_on, ack_rise;

	always_comb
	begin
		filt_nxt = filt_r;
		if (sync2_r.dmack_n == sync3_r.dmack_n)
			filt_nxt.dmack_n = sync3_r.dmack_n;
		if (sync2_r.stop == sync3_r.stop)
			filt_nxt.stop = sync3_r.stop;
		if (sync2_r.hstrobe == sync3_r.hstrobe)
			filt_nxt.hstrobe = sync3_r.hstrobe;
		filt_nxt.dd = sync3_r.dd;
		strobe_edge = (sync2_r.hstrobe == sync3_r.hstrobe) && (sync3_r.hstrobe != filt_r.hstrobe);
		ack_rise = sync2_r.dmack_n && sync3_r.dmack_n && !filt_r.dmack_n;
		ack_on = !filt_r.dmack_n;
		stop_on = filt_r.stop;
	end

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			sync1_r <= '{dmack_n: 1'b1, default: '0};
			sync2_r <= '{dmack_n: 1'b1, default: '0};
			sync3_r <= '{dmack_n: 1'b1, default: '0};
			filt_r <= '{dmack_n: 1'b1, default: '0};
		end
		else
		begin
			sync1_r <= host_in;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
			filt_r <= filt_nxt;
		end
	end

	// Receive buffer
	logic push;
	logic fifo_in_ready;
	logic [$clog2(DEPTH):0] fifo_level;
	logic room;

	udmaw_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(DEPTH)
	) u_fifo (
		.clock(clock),
		.resetn(resetn),
		.in_valid(push),
		.in_ready(fifo_in_ready),
		.in_data(sync3_r.dd),
		.out_valid(rx_valid),
		.out_ready(rx_ready),
		.out_data(rx_data),
		.level(fifo_level)
	);

	assign room = fifo_in_ready && (fifo_level <= ($clog2(DEPTH)+1)'(DEPTH - ROOM_MARGIN));

	// Burst control
	udmaw_state_e st_r, st_nxt;
	udmaw_dout_s out_r, out_nxt;
	logic [2:0] mode_r, mode_nxt;
	logic [3:0] tmr_r, tmr_nxt;
	logic [2:0] since_r, since_nxt;
	logic [15:0] crc_r, crc_nxt;
	logic busy_r, busy_nxt, done_r, done_nxt, err_r, err_nxt;
	logic ss_ok;

	always_comb
	begin
		st_nxt = st_r;
		out_nxt = out_r;
		mode_nxt = mode_r;
		tmr_nxt = (tmr_r != 4'h0) ? tmr_r - 4'h1 : tmr_r;
		crc_nxt = crc_r;
		done_nxt = 1'b0;
		err_nxt = 1'b0;
		push = 1'b0;
		ss_ok = (since_r >= 3'(T_SS_CYC));
		since_nxt = (since_r != 3'h7) ? since_r + 3'h1 : since_r;
		// data lines never driven on writes
		out_nxt.dd_oe = 1'b0;
		out_nxt.dd_o = '0;
		if ((st_r == ST_XFER || st_r == ST_PAUSE || st_r == ST_WAIT_END) && strobe_edge && !stop_on)
		begin
			push = 1'b1;
			since_nxt = 3'h0;
			crc_nxt = udmaw_crc_step(crc_r, sync3_r.dd);
		end
		case (st_r)
			ST_IDLE:
			begin
				out_nxt.dmarq = 1'b0;
				out_nxt.ddmardy_n = 1'b1;
				if (burst_go)
				begin
					mode_nxt = (mode > MODE_MAX) ? MODE_MAX : mode;
					out_nxt.dmarq = 1'b1;
					st_nxt = ST_REQ;
				end
			end
			ST_REQ:
			begin
				if (ack_on && !stop_on)
				begin
					tmr_nxt = 4'(T_MLI_CYC);
					st_nxt = ST_ARM;
				end
			end
			ST_ARM:
			begin
				if (tmr_r == 4'h0 && room)
				begin
					out_nxt.ddmardy_n = 1'b0;
					crc_nxt = CRC_INIT;
					since_nxt = 3'h7;
					st_nxt = ST_XFER;
				end
			end
			ST_XFER:
			begin
				if (stop_on)
				begin
					tmr_nxt = 4'(T_MLI_CYC);
					st_nxt = ST_HSTOP;
				end
				else if (!room || burst_end)
				begin
					out_nxt.ddmardy_n = 1'b1;
					tmr_nxt = udmaw_rp_cycles(mode_r);
					st_nxt = ST_PAUSE;
				end
			end
			ST_PAUSE:
			begin
				if (stop_on)
				begin
					tmr_nxt = 4'(T_MLI_CYC);
					st_nxt = ST_HSTOP;
				end
				else if (burst_end && tmr_r == 4'h0 && ss_ok)
				begin
					out_nxt.dmarq = 1'b0;
					st_nxt = ST_WAIT_END;
				end
				else if (!burst_end && room)
				begin
					out_nxt.ddmardy_n = 1'b0;
					st_nxt = ST_XFER;
				end
			end
			ST_HSTOP:
			begin
				if (tmr_r == 4'h0 && ss_ok)
				begin
					out_nxt.ddmardy_n = 1'b1;
					out_nxt.dmarq = 1'b0;
					st_nxt = ST_WAIT_END;
				end
			end
			ST_WAIT_END:
			begin
				if (ack_rise)
				begin
					// CRC word sampled as acknowledge drops
					done_nxt = 1'b1;
					err_nxt = (sync3_r.dd != crc_nxt);
					out_nxt.ddmardy_n = 1'b1;
					st_nxt = ST_IDLE;
				end
			end
			default:
			begin
				st_nxt = ST_IDLE;
				out_nxt.dmarq = 1'b0;
				out_nxt.ddmardy_n = 1'b1;
			end
		endcase
		busy_nxt = (st_nxt != ST_IDLE);
	end

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			st_r <= ST_IDLE;
			out_r <= '{ddmardy_n: 1'b1, default: '0};
			mode_r <= 3'h0;
			tmr_r <= 4'h0;
			since_r <= 3'h7;
			crc_r <= CRC_INIT;
			busy_r <= 1'b0;
			done_r <= 1'b0;
			err_r <= 1'b0;
		end
		else
		begin
			st_r <= st_nxt;
			out_r <= out_nxt;
			mode_r <= mode_nxt;
			tmr_r <= tmr_nxt;
			since_r <= since_nxt;
			crc_r <= crc_nxt;
			busy_r <= busy_nxt;
			done_r <= done_nxt;
			err_r <= err_nxt;
		end
	end

	assign dev_out = out_r;
	assign busy = busy_r;
	assign done = done_r;
	assign crc_err = err_r;
endmodule : udmaw_dev

// >>> core/udmaw_fifo.sv
`timescale 1ns/10ps
module udmaw_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [$clog2(DEPTH):0] level
);
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 4 || (1 << AW) != DEPTH)
	begin : g_depth_check
		$error("udmaw_fifo: DEPTH must be a power of two, at least 4");
	end

	logic [WIDTH-1:0] mem_r [0:DEPTH-1];
	logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
	logic [AW:0] cnt_r, cnt_nxt;
	logic push, pop;
	logic ready_r, ready_nxt, valid_r, valid_nxt;
	logic [WIDTH-1:0] head_r, head_nxt;

	assign in_ready = ready_r;
	assign out_valid = valid_r;
	assign out_data = head_r;
	assign level = cnt_r;

	always_comb
	begin
		push = in_valid && ready_r;
		pop = valid_r && out_ready;
		wr_nxt = push ? wr_r + 1'b1 : wr_r;
		rd_nxt = pop ? rd_r + 1'b1 : rd_r;
		cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		ready_nxt = (cnt_nxt != (AW+1)'(DEPTH));
		valid_nxt = (cnt_nxt != '0);
		// Head register bypasses the array when the new head is written now
		head_nxt = (push && wr_r == rd_nxt) ? in_data : mem_r[rd_nxt];
	end

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			wr_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
			ready_r <= 1'b1;
			valid_r <= 1'b0;
			head_r <= '0;
		end
		else
		begin
			wr_r <= wr_nxt;
			rd_r <= rd_nxt;
			cnt_r <= cnt_nxt;
			ready_r <= ready_nxt;
			valid_r <= valid_nxt;
			head_r <= head_nxt;
		end
	end

	always_ff @(posedge clock)
	begin
		if (push)
			mem_r[wr_r] <= in_data;
	end
endmodule : udmaw_fifo

// >>> core/udmaw_pkg.sv
package udmaw_pkg;
	localparam int CLK_PERIOD_NS = 20;
	localparam int DATA_W = 16;
	localparam int FIFO_DEPTH = 8;
	localparam int ROOM_MARGIN = 3;
	localparam logic [2:0] MODE_MAX = 3'h5;
	localparam int T_RP_NS [0:5] = '{160, 125, 100, 100, 100, 85};
	localparam int T_SS_NS = 50;
	localparam int T_MLI_NS = 20;
	localparam int T_AZ_NS = 10;
	localparam int T_SS_CYC = (T_SS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int T_MLI_CYC = (T_MLI_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int T_AZ_CYC = (T_AZ_NS / CLK_PERIOD_NS < 1) ? 1 : T_AZ_NS / CLK_PERIOD_NS;
	localparam logic [15:0] CRC_INIT = 16'h4aba;
	localparam logic [15:0] CRC_POLY = 16'h1021;

	typedef struct packed {
		logic dmack_n;
		logic stop;
		logic hstrobe;
		logic [DATA_W-1:0] dd;
	} udmaw_hin_s;

	typedef struct packed {
		logic dmarq;
		logic ddmardy_n;
		logic dd_oe;
		logic [DATA_W-1:0] dd_o;
	} udmaw_dout_s;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_REQ,
		ST_ARM,
		ST_XFER,
		ST_PAUSE,
		ST_HSTOP,
		ST_WAIT_END
	} udmaw_state_e;

	function automatic logic [15:0] udmaw_crc_step(input logic [15:0] crc, input logic [15:0] word);
		logic [15:0] c;
		logic fb;
		c = crc;
		fb = 1'b0;
		for (int i = 15; i >= 0; i--)
		begin
			fb = c[15] ^ word[i];
			c = {c[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
		end
		return c;
	endfunction : udmaw_crc_step

	function automatic logic [3:0] udmaw_rp_cycles(input logic [2:0] mode);
		int ns;
		ns = T_RP_NS[(mode > MODE_MAX) ? 5 : int'(mode)];
		return 4'((ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	endfunction : udmaw_rp_cycles
endpackage : udmaw_pkg

// >>> test/udmaw_dev_bench.sv
`timescale 1ns/10ps
module udmaw_dev_bench;
	import udmaw_pkg::*;
	typedef struct {
		logic [2:0] mode;
		int n;
		logic bad;
		logic err;
	} udmaw_row_s;
	logic clock = 1'h0;
	logic resetn = 1'h0;
	logic [2:0] mode = 3'h0;
	logic burst_go = 1'h0;
	logic burst_end = 1'h0;
	logic rx_ready = 1'h1;
	udmaw_hin_s host_in;
	udmaw_dout_s dev_out;
	logic rx_valid;
	logic busy;
	logic done;
	logic crc_err;
	logic [15:0] rx_data;
	logic [15:0] q[$];
	logic seen;
	logic seen_err;
	int n_errors = 0;
	int n_tests = 0;
	int sent;
	int fails;
	udmaw_row_s rows [0:7] = '{'{3'h0, 3, 1'h0, 1'h0}, '{3'h1, 2, 1'h0, 1'h0}, '{3'h2, 4, 1'h1, 1'h1},
		'{3'h3, 1, 1'h0, 1'h0}, '{3'h4, 2, 1'h0, 1'h0}, '{3'h5, 5, 1'h0, 1'h0}, '{3'h7, 2, 1'h0, 1'h0},
		'{3'h2, 2, 1'h0, 1'h0}};
	always #10 clock = ~clock;
	udmaw_dev uut (.clock(clock), .resetn(resetn), .host_in(host_in), .dev_out(dev_out), .mode(mode),
		.burst_go(burst_go), .burst_end(burst_end), .rx_valid(rx_valid), .rx_ready(rx_ready),
		.rx_data(rx_data), .busy(busy), .done(done), .crc_err(crc_err));
	udmaw_host_model host (.clock(clock), .dev_out(dev_out), .host_in(host_in), .sent(sent), .fails(fails));
	always @(posedge clock)
	begin
		if (rx_valid && rx_ready)
			q.push_back(rx_data);
		if (done)
		begin
			seen <= 1'h1;
			seen_err <= crc_err;
		end
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			n_errors++;
			$display("Error %0t got %h exp %h", $time, got, exp);
		end
	endtask : check
	task automatic complete_run;
		n_errors += fails;
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : complete_run
	task automatic run(input udmaw_row_s r, input logic [15:0] base);
		q.delete();
		seen = 1'h0;
		mode <= r.mode;
		burst_go <= 1'h1;
		@(posedge clock);
		burst_go <= 1'h0;
		host.burst(r.n, base, r.bad);
		for (int k = 0; k < 20 && seen !== 1'h1; k++)
			@(posedge clock);
		check(seen, 1'h1);
		check(busy, 1'h0);
		check(seen_err, r.err);
		check(q.size(), sent);
		foreach (q[i])
			check(q[i], base + 16'(i));
	endtask : run
	initial
	begin
		repeat (5) @(posedge clock);
		check({dev_out.dmarq, dev_out.ddmardy_n, busy, rx_valid}, 4'h4);
		resetn <= 1'h1;
		@(posedge clock);
		foreach (rows[i])
			run(rows[i], 16'(i) << 12);
		fork
			run('{3'h0, 40, 1'h0, 1'h0}, 16'h9000);
			begin
				repeat (60) @(posedge clock);
				burst_end <= 1'h1;
			end
		join
		burst_end <= 1'h0;
		check(sent < 40, 1'h1);
		rx_ready <= 1'h0;
		fork
			run('{3'h5, 12, 1'h0, 1'h0}, 16'ha000);
			begin
				repeat (150) @(posedge clock);
				check({dev_out.dmarq, dev_out.ddmardy_n, busy}, 3'h7);
				rx_ready <= 1'h1;
			end
		join
		check(sent, 12);
		// Reset again between bursts, then one more burst
		resetn <= 1'h0;
		repeat (2) @(posedge clock);
		check({dev_out.dmarq, dev_out.ddmardy_n, busy, rx_valid, done}, 5'h08);
		resetn <= 1'h1;
		@(posedge clock);
		check({dev_out.dmarq, dev_out.ddmardy_n, busy, rx_valid, done}, 5'h08);
		run('{3'h1, 2, 1'h0, 1'h0}, 16'hb000);
		complete_run();
	end
endmodule : udmaw_dev_bench

// >>> test/udmaw_dev_properties.sv
`timescale 1ns/10ps
module udmaw_dev_properties
	import udmaw_pkg::*;
#(
	parameter int DEPTH = 8
) (
	input wire logic clock,
	input wire logic resetn,
	input wire udmaw_pkg::udmaw_hin_s host_in,
	input wire udmaw_pkg::udmaw_dout_s dev_out,
	input wire logic [2:0] mode,
	input wire logic burst_go,
	input wire logic burst_end,
	input wire logic rx_valid,
	input wire logic rx_ready,
	input wire logic [udmaw_pkg::DATA_W-1:0] rx_data,
	input wire logic busy,
	input wire logic done,
	input wire logic crc_err
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (!resetn);
	a_pause_hold: assert property ($rose(dev_out.ddmardy_n) && dev_out.dmarq |-> dev_out.dmarq[*5])
		else $error("request dropped too soon after pause");
	a_pause_mode0: assert property ($rose(dev_out.ddmardy_n) && dev_out.dmarq && mode == 3'h0 |-> dev_out.dmarq[*8])
		else $error("request dropped too soon after pause in mode 0");
	a_strobe_gap: assert property ($changed(host_in.hstrobe) && dev_out.dmarq |-> dev_out.dmarq[*3])
		else $error("request dropped too soon after strobe");
	a_stop_answer: assert property ($rose(host_in.stop) && dev_out.dmarq |=> dev_out.dmarq ##[1:12] !dev_out.dmarq)
		else $error("stop answered too early or never");
	a_lines_free: assert property (!dev_out.dd_oe && dev_out.dd_o == '0)
		else $error("device drives data lines");
	a_idle_ready: assert property (!dev_out.dmarq && host_in.dmack_n |-> dev_out.ddmardy_n)
		else $error("ready asserted outside burst");
	a_busy_req: assert property (dev_out.dmarq |-> busy)
		else $error("request raised while not busy");
	a_ack_done: assert property ($rose(host_in.dmack_n) |-> ##[3:6] done)
		else $error("no done after acknowledge release");
	a_err_pulse: assert property (crc_err |-> done ##1 !done)
		else $error("bad error pulse");
endmodule : udmaw_dev_properties

bind udmaw_dev udmaw_dev_properties #(.DEPTH(DEPTH)) chk (.clock(clock), .resetn(resetn), .host_in(host_in),
	.dev_out(dev_out), .mode(mode), .burst_go(burst_go), .burst_end(burst_end), .rx_valid(rx_valid),
	.rx_ready(rx_ready), .rx_data(rx_data), .busy(busy), .done(done), .crc_err(crc_err));

// >>> test/udmaw_host_model.sv
`timescale 1ns/10ps
module udmaw_host_model
	import udmaw_pkg::*;
(
	input wire logic clock,
	input wire udmaw_pkg::udmaw_dout_s dev_out,
	output udmaw_pkg::udmaw_hin_s host_in,
	output int sent,
	output int fails
);
	logic [15:0] crc;
	logic [15:0] w;
	initial
	begin
		host_in = '{dmack_n: 1'h1, default: '0};
		sent = 0;
		fails = 0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask : tick
	task automatic until_rq(input logic lvl, input int lim);
		int k;
		for (k = 0; k < lim && dev_out.dmarq !== lvl; k++)
			tick(1);
		if (k == lim)
			fails++;
	endtask : until_rq
	task automatic burst(input int n, input logic [15:0] base, input logic bad);
		sent = 0;
		crc = CRC_INIT;
		until_rq(1'h1, 20);
		host_in.dmack_n <= 1'h0;
		while (sent < n && dev_out.dmarq)
		begin
			for (int k = 0; k < 400 && dev_out.ddmardy_n && dev_out.dmarq; k++)
				tick(1);
			if (dev_out.ddmardy_n && dev_out.dmarq)
			begin
				fails++;
				break;
			end
			if (!dev_out.dmarq)
				break;
			w = base + 16'(sent);
			for (int b = 15; b >= 0; b--)
				crc = {crc[14:0], 1'h0} ^ ((crc[15] ^ w[b]) ? CRC_POLY : 16'h0000);
			host_in.dd <= w;
			tick(4);
			host_in.hstrobe <= ~host_in.hstrobe;
			tick(4);
			sent++;
		end
		if (dev_out.dmarq)
			host_in.stop <= 1'h1;
		until_rq(1'h0, 40);
		host_in.stop <= 1'h1;
		host_in.dd <= crc ^ {15'h0, bad};
		tick(4);
		host_in.dmack_n <= 1'h1;
		tick(4);
		host_in.stop <= 1'h0;
		host_in.dd <= ~crc;
	endtask : burst
endmodule : udmaw_host_model
